// File: trip_matrix_defs.svh
// register map, field positions, reset values for the trip latch and output matrix
// assumes a 32-bit apb bus with word-aligned registers
`ifndef TRIP_MATRIX_DEFS_SVH
`define TRIP_MATRIX_DEFS_SVH

`define ADDR_W 8
`define OFS_BLOCKING 8'h00
`define OFS_START_TRIP 8'h04
`define OFS_SIGNAL_ROUTE 8'h08
`define OFS_AUX_ROUTE 8'h0c
`define OFS_FUNC_ONE 8'h10
`define OFS_IRQ_STATUS 8'h14
`define OFS_IRQ_MASK 8'h18
`define OFS_OUT_STATE 8'h1c
`define OFS_CURRENTS 8'h20
`define OFS_RECORDED 8'h24

`define RST_BLOCKING 8'h00
`define RST_START_TRIP 8'hab
`define RST_SIGNAL_ROUTE 8'ha5
`define RST_AUX_ROUTE 8'h00
`define RST_FUNC_ONE 8'h00

// blocking_control_switches bits (switch n at bit n-1)
`define BLK_STAGE_LSB 0
`define BLK_PHASE_LATCH 5
`define BLK_EARTH_LATCH 6
`define BLK_REMOTE_RESET 7
// function_switch_group_one bit of switch 4
`define FUNC_BREAKER_FAIL 3

// interrupt status bits
`define IRQ_W 4
`define IRQ_MAIN_TRIP 0
`define IRQ_AUX_TRIP 1
`define IRQ_LATCH_CLEAR 2
`define IRQ_EXT_CTRL 3

`define STAGES 4
`define PHASE_W 6
`define RESIDUAL_W 5
`define RESIDUAL_MAX 5'h15

`endif

// File: trip_matrix_pkg.sv
// types for the trip latch and output matrix
// assumes trip_matrix_defs.svh is on the include path
`include "trip_matrix_defs.svh"

package trip_matrix_pkg;

   typedef struct packed {
      logic [7:0] blocking;
      logic [7:0] start_trip;
      logic [7:0] signal_route;
      logic [7:0] aux_route;
      logic [7:0] func_one;
      logic [`IRQ_W-1:0] irq_status;
      logic [`IRQ_W-1:0] irq_mask;
      logic phase_latch;
      logic earth_latch;
      logic [2:0] ext_sync;
      logic [2:0] rst_btn_sync;
      logic [2:0] prog_btn_sync;
      logic ext_q;
      logic rst_btn_q;
      logic prog_btn_q;
      logic main_trip;
      logic aux_trip;
      logic first_start;
      logic second_signal;
      logic third_signal;
      logic [`PHASE_W-1:0] l1;
      logic [`PHASE_W-1:0] l2;
      logic [`PHASE_W-1:0] l3;
      logic [`RESIDUAL_W-1:0] residual;
      logic [`PHASE_W-1:0] rec_l1;
      logic [`PHASE_W-1:0] rec_l2;
      logic [`PHASE_W-1:0] rec_l3;
      logic [`RESIDUAL_W-1:0] rec_residual;
      logic ack;
      logic err;
      logic [31:0] rdata;
   } trip_state_t;

endpackage

// File: trip_latch_output_matrix.sv
// trip latching, latch reset and output routing matrices of a protection relay
// assumes stage start/operate and currents come from logic on clk; buttons and
// external control input are pins; software reaches registers over apb
`timescale 1ns/1ps

module trip_latch_output_matrix
   import trip_matrix_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [`STAGES-1:0] stage_start,
   input wire logic [`STAGES-1:0] stage_operate,
   input wire logic breaker_failure,
   input wire logic external_control_input,
   input wire logic reset_button,
   input wire logic program_button,
   input wire logic [`PHASE_W-1:0] phase_l1_current,
   input wire logic [`PHASE_W-1:0] phase_l2_current,
   input wire logic [`PHASE_W-1:0] phase_l3_current,
   input wire logic [`RESIDUAL_W-1:0] residual_current,
   output logic main_trip_output,
   output logic aux_trip_output,
   output logic first_start_output,
   output logic second_signal_output,
   output logic third_signal_output,
   output logic irq,
   output logic [`PHASE_W-1:0] phase_l1_shown,
   output logic [`PHASE_W-1:0] phase_l2_shown,
   output logic [`PHASE_W-1:0] phase_l3_shown,
   output logic [`RESIDUAL_W-1:0] residual_shown
);

   trip_state_t state_r;
   trip_state_t state_nxt;

   logic [`STAGES-1:0] start_ok;
   logic [`STAGES-1:0] oper_ok;
   logic [`STAGES-1:0] to_start1;
   logic [`STAGES-1:0] to_trip_phase;
   logic [`STAGES-1:0] to_signal2;
   logic [`STAGES-1:0] to_signal3;
   logic [`STAGES-1:0] to_aux;

   // blocking and per-stage routing terms
   genvar g;
   generate
      for (g = 0; g < `STAGES; g++) begin : g_stage
         assign start_ok[g] = stage_start[g] &
            ~(state_r.blocking[`BLK_STAGE_LSB + g] & state_r.ext_q);
         assign oper_ok[g] = stage_operate[g] &
            ~(state_r.blocking[`BLK_STAGE_LSB + g] & state_r.ext_q);
         assign to_start1[g] = start_ok[g] & state_r.start_trip[2*g];
         assign to_trip_phase[g] = oper_ok[g] & state_r.start_trip[2*g+1];
         assign to_signal2[g] = oper_ok[g] & state_r.signal_route[2*g];
         assign to_signal3[g] = oper_ok[g] & state_r.signal_route[2*g+1];
         assign to_aux[g] = (start_ok[g] & state_r.aux_route[2*g]) |
            (oper_ok[g] & state_r.aux_route[2*g+1]);
      end
   endgenerate

   logic phase_trip;
   logic earth_trip;
   logic both_buttons;
   logic prog_only;
   logic remote_reset;
   logic latch_clear;
   logic records_clear;
   logic wr_en;
   logic setup;
   logic [`ADDR_W-1:0] addr;
   logic addr_ok;
   logic [31:0] rd_val;
   logic [`IRQ_W-1:0] events;

   assign phase_trip = to_trip_phase[0] | to_trip_phase[1];
   assign earth_trip = to_trip_phase[2] | to_trip_phase[3];
   assign both_buttons = state_r.rst_btn_q & state_r.prog_btn_q;
   assign prog_only = state_r.prog_btn_q & ~state_r.rst_btn_q;
   assign remote_reset = state_r.ext_q & state_r.blocking[`BLK_REMOTE_RESET] &
      (state_r.blocking[`BLK_PHASE_LATCH] | state_r.blocking[`BLK_EARTH_LATCH]);
   assign latch_clear = both_buttons | prog_only | remote_reset;
   // program alone leaves the recorded values alone
   assign records_clear = both_buttons | remote_reset;

   assign addr = paddr[`ADDR_W-1:0];
   assign addr_ok = (paddr[31:`ADDR_W] == 24'h000000) && (addr[1:0] == 2'h0) &&
      (addr <= `OFS_RECORDED);
   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pready & pwrite & ~state_r.err;

   always_comb begin
      rd_val = 32'h00000000;
      case (addr)
         `OFS_BLOCKING: rd_val = {24'h000000, state_r.blocking};
         `OFS_START_TRIP: rd_val = {24'h000000, state_r.start_trip};
         `OFS_SIGNAL_ROUTE: rd_val = {24'h000000, state_r.signal_route};
         `OFS_AUX_ROUTE: rd_val = {24'h000000, state_r.aux_route};
         `OFS_FUNC_ONE: rd_val = {24'h000000, state_r.func_one};
         `OFS_IRQ_STATUS: rd_val = {28'h0000000, state_r.irq_status};
         `OFS_IRQ_MASK: rd_val = {28'h0000000, state_r.irq_mask};
         `OFS_OUT_STATE: rd_val = {23'h000000, state_r.ext_q, state_r.earth_latch,
            state_r.phase_latch, state_r.third_signal, state_r.second_signal,
            state_r.first_start, state_r.aux_trip, state_r.main_trip};
         `OFS_CURRENTS: rd_val = {9'h000, state_r.residual, state_r.l3, state_r.l2,
            state_r.l1};
         `OFS_RECORDED: rd_val = {9'h000, state_r.rec_residual, state_r.rec_l3,
            state_r.rec_l2, state_r.rec_l1};
         default: rd_val = 32'h00000000;
      endcase
   end

   always_comb begin
      state_nxt = state_r;

      // three-stage pin synchronisers, change accepted when last two agree
      state_nxt.ext_sync = {state_r.ext_sync[1:0], external_control_input};
      state_nxt.rst_btn_sync = {state_r.rst_btn_sync[1:0], reset_button};
      state_nxt.prog_btn_sync = {state_r.prog_btn_sync[1:0], program_button};
      if (state_r.ext_sync[1] == state_r.ext_sync[2]) begin
         state_nxt.ext_q = state_r.ext_sync[2];
      end
      if (state_r.rst_btn_sync[1] == state_r.rst_btn_sync[2]) begin
         state_nxt.rst_btn_q = state_r.rst_btn_sync[2];
      end
      if (state_r.prog_btn_sync[1] == state_r.prog_btn_sync[2]) begin
         state_nxt.prog_btn_q = state_r.prog_btn_sync[2];
      end

      // latches: an active operate keeps the latch set even during a clear
      if (latch_clear) begin
         state_nxt.phase_latch = 1'b0;
         state_nxt.earth_latch = 1'b0;
      end
      if (phase_trip & state_r.blocking[`BLK_PHASE_LATCH]) begin
         state_nxt.phase_latch = 1'b1;
      end
      if (earth_trip & state_r.blocking[`BLK_EARTH_LATCH]) begin
         state_nxt.earth_latch = 1'b1;
      end

      // without latching the trip follows the operate term directly
      state_nxt.main_trip = phase_trip | earth_trip | state_nxt.phase_latch |
         state_nxt.earth_latch;
      state_nxt.first_start = |to_start1;
      state_nxt.second_signal = |to_signal2;
      state_nxt.third_signal = |to_signal3;
      state_nxt.aux_trip = (|to_aux) |
         (state_r.func_one[`FUNC_BREAKER_FAIL] & breaker_failure);

      // measured values, residual saturates at its full-scale figure
      state_nxt.l1 = phase_l1_current;
      state_nxt.l2 = phase_l2_current;
      state_nxt.l3 = phase_l3_current;
      state_nxt.residual = (residual_current > `RESIDUAL_MAX) ? `RESIDUAL_MAX :
         residual_current;

      // values memorised at the moment of operation
      if (records_clear) begin
         state_nxt.rec_l1 = '0;
         state_nxt.rec_l2 = '0;
         state_nxt.rec_l3 = '0;
         state_nxt.rec_residual = '0;
      end
      if (phase_trip & ~state_r.main_trip) begin
         state_nxt.rec_l1 = state_r.l1;
         state_nxt.rec_l2 = state_r.l2;
         state_nxt.rec_l3 = state_r.l3;
      end
      if (earth_trip & ~state_r.main_trip) begin
         state_nxt.rec_residual = state_r.residual;
      end

      // apb: read data and error captured in setup, answered and written in the first access cycle
      state_nxt.ack = setup;
      if (setup) begin
         state_nxt.err = ~addr_ok;
         state_nxt.rdata = (addr_ok & ~pwrite) ? rd_val : 32'h00000000;
      end
      if (wr_en) begin
         case (addr)
            `OFS_BLOCKING: state_nxt.blocking = pwdata[7:0];
            `OFS_START_TRIP: state_nxt.start_trip = pwdata[7:0];
            `OFS_SIGNAL_ROUTE: state_nxt.signal_route = pwdata[7:0];
            `OFS_AUX_ROUTE: state_nxt.aux_route = pwdata[7:0];
            `OFS_FUNC_ONE: state_nxt.func_one = pwdata[7:0];
            `OFS_IRQ_MASK: state_nxt.irq_mask = pwdata[`IRQ_W-1:0];
            default: state_nxt.func_one = state_r.func_one;
         endcase
      end

      // sticky events: clear by writing one, a fresh event wins over the clear
      events = '0;
      events[`IRQ_MAIN_TRIP] = state_nxt.main_trip & ~state_r.main_trip;
      events[`IRQ_AUX_TRIP] = state_nxt.aux_trip & ~state_r.aux_trip;
      events[`IRQ_LATCH_CLEAR] = latch_clear & (state_r.phase_latch | state_r.earth_latch);
      events[`IRQ_EXT_CTRL] = state_nxt.ext_q & ~state_r.ext_q;
      if (wr_en && addr == `OFS_IRQ_STATUS) begin
         state_nxt.irq_status = state_r.irq_status & ~pwdata[`IRQ_W-1:0];
      end
      state_nxt.irq_status = state_nxt.irq_status | events;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= '0;
         state_r.blocking <= `RST_BLOCKING;
         state_r.start_trip <= `RST_START_TRIP;
         state_r.signal_route <= `RST_SIGNAL_ROUTE;
         state_r.aux_route <= `RST_AUX_ROUTE;
         state_r.func_one <= `RST_FUNC_ONE;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign pready = state_r.ack;
   assign pslverr = state_r.ack & state_r.err;
   assign prdata = state_r.rdata;
   assign main_trip_output = state_r.main_trip;
   assign aux_trip_output = state_r.aux_trip;
   assign first_start_output = state_r.first_start;
   assign second_signal_output = state_r.second_signal;
   assign third_signal_output = state_r.third_signal;
   assign irq = |(state_r.irq_status & state_r.irq_mask);
   assign phase_l1_shown = state_r.l1;
   assign phase_l2_shown = state_r.l2;
   assign phase_l3_shown = state_r.l3;
   assign residual_shown = state_r.residual;

endmodule

// File: trip_matrix_asserts.sv
// port-level assertions for the trip latch and output matrix
// assumes bind onto trip_latch_output_matrix, single clock domain
`timescale 1ns/1ps
`include "trip_matrix_defs.svh"
module trip_matrix_asserts (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [`STAGES-1:0] stage_start,
   input wire logic [`STAGES-1:0] stage_operate,
   input wire logic breaker_failure,
   input wire logic main_trip_output,
   input wire logic aux_trip_output,
   input wire logic first_start_output,
   input wire logic second_signal_output,
   input wire logic third_signal_output,
   input wire logic [`PHASE_W-1:0] phase_l1_current,
   input wire logic [`PHASE_W-1:0] phase_l1_shown,
   input wire logic [`RESIDUAL_W-1:0] residual_shown
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_quiet;
      !(|stage_start) && !(|stage_operate) && !breaker_failure;
   endsequence
   chk_apb_ready_once: assert property (s_setup |=> pready ##1 !pready)
      else $error("apb answer not single cycle");
   chk_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   chk_start_cause: assert property ($rose(first_start_output) |-> $past(|stage_start))
      else $error("start output without start");
   chk_main_cause: assert property ($rose(main_trip_output) |-> $past(|stage_operate))
      else $error("trip without operate");
   chk_signal_cause: assert property (($rose(second_signal_output) || $rose(third_signal_output))
      |-> $past(|stage_operate))
      else $error("signal output without operate");
   chk_aux_cause: assert property ($rose(aux_trip_output)
      |-> $past(|stage_start || |stage_operate || breaker_failure))
      else $error("aux trip without cause");
   chk_quiet_outputs: assert property (s_quiet ##1 s_quiet |=> !first_start_output
      && !second_signal_output && !third_signal_output && !aux_trip_output)
      else $error("output active with no source");
   chk_phase_shown: assert property ($past(rst_b) |-> phase_l1_shown == $past(phase_l1_current))
      else $error("phase value not shown");
   chk_resid_clamp: assert property (residual_shown <= 5'h15)
      else $error("residual above range");
endmodule
bind trip_latch_output_matrix trip_matrix_asserts u_chk (.clk(clk), .rst_b(rst_b), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .stage_start(stage_start),
   .stage_operate(stage_operate), .breaker_failure(breaker_failure),
   .main_trip_output(main_trip_output), .aux_trip_output(aux_trip_output),
   .first_start_output(first_start_output), .second_signal_output(second_signal_output),
   .third_signal_output(third_signal_output), .phase_l1_current(phase_l1_current),
   .phase_l1_shown(phase_l1_shown), .residual_shown(residual_shown));

// File: output_relay_bank.sv
// output relays hanging on the block's five outputs
// assumes coils sampled on the block clock
`timescale 1ns/1ps
module output_relay_bank (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [4:0] coils,
   output logic [4:0] contacts
);
   // one-cycle pick-up; real relays are far slower, kept short for run time
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         contacts <= 5'h0;
      else
         contacts <= coils;
   end
endmodule

// File: test_trip_latch_output_matrix.sv
// self-checking bench for the trip latch and output matrix
// assumes apb master here, relay bank model on the outputs
`timescale 1ns/1ps
`include "trip_matrix_defs.svh"
module test_trip_latch_output_matrix import trip_matrix_pkg::*;;
   logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, err, pready, pslverr;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, rd, prdata;
   logic [3:0] stage_start = 4'h0, stage_operate = 4'h0;
   logic breaker_failure = 0, ext = 0, rbtn = 0, pbtn = 0;
   logic main_t, aux_t, fs, ss2, ss3, irq;
   logic [5:0] l1 = 6'h0, l2 = 6'h0, l3 = 6'h0, s1, s2, s3;
   logic [4:0] res = 5'h0, sr, outs, contacts;
   int n_mismatch = 0, checks_done = 0, cyc = 0;
   assign outs = {aux_t, ss3, ss2, fs, main_t};
   always #2 clk = ~clk;
   trip_latch_output_matrix dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .stage_start(stage_start), .stage_operate(stage_operate),
      .breaker_failure(breaker_failure), .external_control_input(ext), .reset_button(rbtn),
      .program_button(pbtn), .phase_l1_current(l1), .phase_l2_current(l2),
      .phase_l3_current(l3), .residual_current(res), .main_trip_output(main_t),
      .aux_trip_output(aux_t), .first_start_output(fs), .second_signal_output(ss2),
      .third_signal_output(ss3), .irq(irq), .phase_l1_shown(s1), .phase_l2_shown(s2),
      .phase_l3_shown(s3), .residual_shown(sr));
   output_relay_bank relays (.clk(clk), .rst_b(rst_b), .coils(outs), .contacts(contacts));
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         final_report;
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // holds the request until pready is seen at an edge
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      @(posedge clk);
      // only the bench timeout ends a wait for the answer
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clk);
   endtask
   task automatic op(input logic [3:0] m);
      stage_operate <= m;
      tick(2);
      stage_operate <= 4'h0;
      tick(2);
   endtask
   // pins pass a 3-flop sync, so hold them well past its latency
   task automatic press(input logic r, input logic p, input logic e);
      rbtn <= r;
      pbtn <= p;
      ext <= e;
      tick(8);
      rbtn <= 0;
      pbtn <= 0;
      ext <= 0;
      tick(8);
   endtask
   task automatic t_defaults;
      xfer(0, `OFS_BLOCKING, 0);
      chk(rd, 32'h0);
      xfer(0, `OFS_START_TRIP, 0);
      chk(rd, 32'hab);
      xfer(0, `OFS_SIGNAL_ROUTE, 0);
      chk(rd, 32'ha5);
      xfer(0, `OFS_AUX_ROUTE, 0);
      chk(rd, 32'h0);
      xfer(0, 32'h30, 0);
      chk(err, 1'b1);
      $display("defaults done");
   endtask
   task automatic route(input logic [7:0] r1, input logic [7:0] r2, input logic [7:0] r3);
      xfer(1, `OFS_START_TRIP, r1);
      xfer(1, `OFS_SIGNAL_ROUTE, r2);
      xfer(1, `OFS_AUX_ROUTE, r3);
      for (int i = 0; i < 4; i++) begin
         stage_start <= 4'h1 << i;
         tick(2);
         chk(outs, {r3[2*i], 2'b00, r1[2*i], 1'b0});
         stage_start <= 4'h0;
         stage_operate <= 4'h1 << i;
         tick(2);
         chk(outs, {r3[2*i+1], r2[2*i+1], r2[2*i], 1'b0, r1[2*i+1]});
         stage_operate <= 4'h0;
         tick(2);
         chk(outs, 5'h0);
      end
      $display("route done");
   endtask
   task automatic t_latch;
      l1 <= 6'h05;
      l2 <= 6'h06;
      l3 <= 6'h07;
      res <= 5'h03;
      xfer(1, `OFS_BLOCKING, 32'h20);
      op(4'h4);
      chk(main_t, 1'b0);
      op(4'h1);
      chk(main_t, 1'b1);
      press(0, 1, 0);
      chk(main_t, 1'b0);
      xfer(0, `OFS_RECORDED, 0);
      chk(rd, {9'h0, 5'h03, 6'h07, 6'h06, 6'h05});
      op(4'h1);
      press(1, 1, 0);
      chk(main_t, 1'b0);
      xfer(0, `OFS_RECORDED, 0);
      chk(rd, 32'h0);
      xfer(1, `OFS_BLOCKING, 32'ha0);
      op(4'h1);
      press(0, 0, 1);
      chk(main_t, 1'b0);
      xfer(1, `OFS_BLOCKING, 32'h40);
      op(4'h8);
      chk(main_t, 1'b1);
      press(0, 1, 0);
      xfer(1, `OFS_BLOCKING, 32'h0f);
      ext <= 1;
      tick(8);
      stage_operate <= 4'hf;
      tick(3);
      chk(main_t, 1'b0);
      ext <= 0;
      tick(8);
      chk(main_t, 1'b1);
      stage_operate <= 4'h0;
      xfer(1, `OFS_BLOCKING, 32'h0);
      $display("latch and blocking done");
   endtask
   task automatic t_misc;
      xfer(1, `OFS_FUNC_ONE, 32'h08);
      breaker_failure <= 1;
      tick(2);
      chk(aux_t, 1'b1);
      tick(1);
      chk(contacts[4], 1'b1);
      breaker_failure <= 0;
      xfer(1, `OFS_IRQ_STATUS, 32'hf);
      xfer(1, `OFS_IRQ_MASK, 32'h1);
      chk(irq, 1'b0);
      op(4'h1);
      chk(irq, 1'b1);
      xfer(0, `OFS_IRQ_STATUS, 0);
      chk(rd, 32'h1);
      xfer(1, `OFS_IRQ_STATUS, 32'h1);
      chk(irq, 1'b0);
      xfer(1, `OFS_IRQ_MASK, 32'h0);
      op(4'h1);
      chk(irq, 1'b0);
      l1 <= 6'h3f;
      res <= 5'h1f;
      tick(2);
      chk(s1, 6'h3f);
      chk(s2, 6'h06);
      chk(s3, 6'h07);
      chk(sr, 5'h15);
      $display("misc done");
   endtask
   initial begin
      tick(20);
      rst_b <= 1;
      tick(1);
      t_defaults;
      route(8'h54, 8'h5a, 8'hff);
      route(8'hab, 8'ha5, 8'h00);
      t_latch;
      t_misc;
      final_report;
   end
endmodule
